// *** rtl/fcd_dma.v ***
// Four-channel DMA controller: register file on Avalon-MM, arbiter and
// a single dual-address transfer engine driving a simple memory master.
// Assumes the memory side answers with mem_ack for one cycle per access.
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`include "fcd_map.vh"

// Summary of operation
// [R1] Four independent channels move data without the processor.
// [R2] Each unit is 8, 16 or 32 bits wide, chosen per channel.
// [R3] Up to 16,777,216 transfers per programmed operation.
// [R4] Direct mode: one read cycle then one write cycle per unit.
// [R5] Indirect mode: fetch data address at source first, then transfer.
// [R6] Indirect addressing exists on channel 3 only, software-selectable.
// [R7] Channel 2 alone reloads its original source every four transfers.
// [R8] Channels 0 and 1 take external requests, edge or level detected.
// [R9] Every channel accepts on-chip peripheral requests.
// [R10] Auto-request mode generates requests internally.
// [R11] Cycle-steal releases bus between units; burst keeps it.
// [R12] Fixed priority keeps a constant channel order.
// [R13] Round-robin makes the just-served channel lowest.
// [R14] Interrupt raised at end of count when enabled.
// [R15] Count one means one transfer; zero means 16,777,216.
// [R16] Acknowledge strobe to external requester on channels 0 and 1.
// [R17] Flags cleared only by writing zero after reading one.
// [R18] Addresses and count update per unit; stop at count exhausted.
module fcd_dma (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output reg  [1:0]  avs_response,
   input  wire [1:0]  ext_transfer_request,
   output reg  [1:0]  transfer_ack_strobe,
   input  wire [3:0]  peri_request,
   output reg  [3:0]  peri_ack,
   output reg  [31:0] mem_address,
   output reg         mem_read,
   output reg         mem_write,
   output reg  [31:0] mem_writedata,
   output reg  [3:0]  mem_byteenable,
   input  wire [31:0] mem_readdata,
   input  wire        mem_ack,
   output wire        irq
);

   // ****************************************************************
   // Engine states
   // ****************************************************************
   localparam ST_IDLE  = 3'h0;
   localparam ST_FETCH = 3'h1;
   localparam ST_READ  = 3'h2;
   localparam ST_WRITE = 3'h3;
   localparam ST_NEXT  = 3'h4;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg  [31:0] src_addr [0:3];
   reg  [31:0] dst_addr [0:3];
   reg  [31:0] src_orig [0:3];
   reg  [23:0] remaining_transfer_count [0:3];
   reg  [31:0] channel_control [0:3];
   reg  [15:0] shared_operation_control;
   reg  [3:0]  done_seen;
   reg         err_seen;
   reg  [1:0]  reload_cnt;
   reg  [1:0]  ext_prev;
   reg  [1:0]  ext_pend;
   reg  [1:0]  ack_cnt [0:1];
   reg  [2:0]  state;
   reg  [1:0]  cur;
   reg  [1:0]  last_served;
   reg  [31:0] rd_addr;
   reg         ack_pending;
   reg         rd_wait;
   reg  [3:0]  req;
   reg         grant_valid;
   reg  [1:0]  grant;
   integer     i;
   integer     k;
   reg  [1:0]  cand;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function [31:0] unit_step;
      input [1:0] sz;
      begin
         case (sz)
            `FCD_SZ_8:  unit_step = 32'h0000_0001;
            `FCD_SZ_16: unit_step = 32'h0000_0002;
            default:    unit_step = 32'h0000_0004;
         endcase
      end
   endfunction

   function [3:0] lane_mask;
      input [1:0]  sz;
      input [31:0] a;
      begin
         case (sz)
            `FCD_SZ_8:  lane_mask = 4'h1 << a[1:0];
            `FCD_SZ_16: lane_mask = a[1] ? 4'hc : 4'h3;
            default:    lane_mask = 4'hf;
         endcase
      end
   endfunction

   function [31:0] merge_be;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer b;
      begin
         merge_be = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b])
               merge_be[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // ****************************************************************
   // Request detection
   // ****************************************************************
   wire [3:0] ch_en;
   wire [3:0] ch_irq;
   wire       dma_on = shared_operation_control[`FCD_OP_ENABLE] & ~err_seen;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_req // see [R1]
         wire [1:0] rsrc = channel_control[g][`FCD_CTL_SRC_H:`FCD_CTL_SRC_L];
         assign ch_en[g] = channel_control[g][`FCD_CTL_EN] &
                           ~channel_control[g][`FCD_CTL_DONE] & dma_on;
         assign ch_irq[g] = channel_control[g][`FCD_CTL_DONE] &
                            channel_control[g][`FCD_CTL_IE];
         always @* begin
            case (rsrc)
               `FCD_SRC_AUTO: req[g] = ch_en[g];               // see [R10]
               `FCD_SRC_PERI: req[g] = ch_en[g] & peri_request[g]; // see [R9]
               `FCD_SRC_EXT:  req[g] = (g < 2) ? ch_en[g] & ext_pend[g % 2]
                                               : 1'b0;          // see [R8]
               default:       req[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Edge mode latches a rising edge; level mode follows the pin
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_prev <= 2'h0;
         ext_pend <= 2'h0;
      end else begin
         ext_prev <= ext_transfer_request;
         for (i = 0; i < 2; i = i + 1) begin
            if (channel_control[i][`FCD_CTL_EXT_EDGE]) begin
               if (ext_transfer_request[i] & ~ext_prev[i])
                  ext_pend[i] <= 1'b1;                          // see [R8]
               else if (state == ST_NEXT && cur == i)
                  ext_pend[i] <= 1'b0;
            end else begin
               ext_pend[i] <= ext_transfer_request[i];          // see [R8]
            end
         end
      end
   end

   // ****************************************************************
   // Arbiter
   // ****************************************************************
   always @* begin
      grant_valid = 1'b0;
      grant       = 2'h0;
      cand        = 2'h0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (shared_operation_control[`FCD_OP_RROBIN])
            cand = last_served + 2'h1 + k[1:0];                 // see [R13]
         else
            cand = k[1:0];                                      // see [R12]
         if (req[cand]) begin
            grant_valid = 1'b1;
            grant       = cand;
         end
      end
   end

   // ****************************************************************
   // Avalon-MM slave: reads wait one cycle, decode by offset
   // ****************************************************************
   // The wait lets registered read data stand at the accepting edge
   wire rd_take = avs_read & ~rd_wait;
   assign avs_waitrequest = rd_take;

   wire [7:0] rel     = avs_address - `FCD_CH_BASE;
   wire       ch_hit  = (avs_address >= `FCD_CH_BASE) &&
                        (avs_address < `FCD_OPER_ADDR) &&
                        (avs_address[1:0] == 2'h0);
   wire [1:0] ch_sel  = rel[5:4];
   wire [1:0] reg_sel = rel[3:2];
   wire       op_hit  = (avs_address == `FCD_OPER_ADDR);
   wire [31:0] ctl_rd = channel_control[ch_sel] & `FCD_CTL_MASK;
   wire [31:0] op_wr  = merge_be({16'h0, shared_operation_control},
                                 avs_writedata, avs_byteenable);
   // Count keeps 24 bits; upper write bits are dropped
   wire [31:0] cnt_wr = merge_be({8'h0, remaining_transfer_count[ch_sel]},
                                 avs_writedata, avs_byteenable); // see [R3]

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= 32'h0;
         avs_response <= 2'h0;
      end else if (rd_take) begin
         avs_response <= (ch_hit | op_hit) ? 2'h0 : 2'h3;
         avs_readdata <= 32'h0;
         if (op_hit)
            avs_readdata <= {16'h0, shared_operation_control} |
                            {30'h0, err_seen, 1'b0};
         else if (ch_hit) begin
            case (reg_sel)
               `FCD_OFS_SRC: avs_readdata <= src_addr[ch_sel];
               `FCD_OFS_DST: avs_readdata <= dst_addr[ch_sel];
               `FCD_OFS_CNT: avs_readdata <=
                  {8'h0, remaining_transfer_count[ch_sel]};
               default:      avs_readdata <= ctl_rd;
            endcase
         end
      end else if (avs_write) begin
         avs_response <= (ch_hit | op_hit) ? 2'h0 : 2'h3;
      end
   end

   // ****************************************************************
   // Engine and register file (one writer for shared state)
   // ****************************************************************
   wire [31:0] cctl  = channel_control[cur];
   wire [1:0]  csz   = cctl[`FCD_CTL_SZ_HI:`FCD_CTL_SZ_LO];
   wire        cind  = (cur == 2'h3) & cctl[`FCD_CTL_INDIRECT]; // see [R6]
   wire        crel  = (cur == 2'h2) & cctl[`FCD_CTL_RELOAD];   // see [R7]
   wire [23:0] cnt_next = remaining_transfer_count[cur] - 24'h1;
   wire        last_unit = (cnt_next == 24'h0);  // zero start wraps: see [R15]

   assign irq = |ch_irq;                                         // see [R14]

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state          <= ST_IDLE;
         cur            <= 2'h0;
         last_served    <= 2'h3;
         mem_address    <= 32'h0;
         mem_read       <= 1'b0;
         mem_write      <= 1'b0;
         mem_writedata  <= 32'h0;
         mem_byteenable <= 4'h0;
         rd_addr        <= 32'h0;
         reload_cnt     <= 2'h0;
         done_seen      <= 4'h0;
         err_seen       <= 1'b0;
         ack_pending    <= 1'b0;
         rd_wait        <= 1'b0;
         peri_ack       <= 4'h0;
         shared_operation_control <= 16'h0;
         for (i = 0; i < 4; i = i + 1) begin
            src_addr[i] <= 32'h0;
            dst_addr[i] <= 32'h0;
            src_orig[i] <= 32'h0;
            remaining_transfer_count[i] <= 24'h0;
            channel_control[i] <= 32'h0;
         end
      end else begin
         peri_ack <= 4'h0;
         rd_wait  <= rd_take;
         // Software access; flags clear only by zero after a one was read
         if (rd_take & ch_hit & (reg_sel == `FCD_OFS_CTL) &
             ctl_rd[`FCD_CTL_DONE])
            done_seen[ch_sel] <= 1'b1;                           // see [R17]
         if (rd_take & op_hit & err_seen)
            ack_pending <= 1'b1;
         if (avs_write & op_hit) begin
            shared_operation_control <= op_wr[15:0] & `FCD_OP_MASK;
            if (ack_pending & ~avs_writedata[`FCD_OP_ERR] &
                avs_byteenable[0]) begin
               err_seen    <= 1'b0;                              // see [R17]
               ack_pending <= 1'b0;
            end
         end
         if (avs_write & ch_hit) begin
            case (reg_sel)
               `FCD_OFS_SRC: begin
                  src_addr[ch_sel] <= merge_be(src_addr[ch_sel],
                     avs_writedata, avs_byteenable);
                  src_orig[ch_sel] <= merge_be(src_addr[ch_sel],
                     avs_writedata, avs_byteenable);
               end
               `FCD_OFS_DST: dst_addr[ch_sel] <= merge_be(
                  dst_addr[ch_sel], avs_writedata, avs_byteenable);
               `FCD_OFS_CNT: remaining_transfer_count[ch_sel] <= cnt_wr[23:0];
               default: begin
                  channel_control[ch_sel] <= (merge_be(
                     channel_control[ch_sel], avs_writedata,
                     avs_byteenable) & `FCD_CTL_MASK & ~32'h2) |
                     (channel_control[ch_sel] & 32'h2);
                  if (done_seen[ch_sel] & avs_byteenable[0] &
                      ~avs_writedata[`FCD_CTL_DONE]) begin
                     channel_control[ch_sel][`FCD_CTL_DONE] <= 1'b0; // see [R17]
                     done_seen[ch_sel] <= 1'b0;
                  end
               end
            endcase
         end

         // Transfer engine; hardware updates win over software writes
         case (state)
            ST_IDLE: begin
               if (grant_valid) begin
                  cur         <= grant;
                  last_served <= grant;                          // see [R13]
                  if ((grant == 2'h3) &
                      channel_control[3][`FCD_CTL_INDIRECT]) begin
                     mem_address    <= src_addr[grant];          // see [R5]
                     mem_byteenable <= 4'hf;
                     mem_read       <= 1'b1;
                     state          <= ST_FETCH;
                  end else begin
                     rd_addr        <= src_addr[grant];          // see [R4]
                     mem_address    <= src_addr[grant];
                     mem_byteenable <= lane_mask(channel_control[grant]
                        [`FCD_CTL_SZ_HI:`FCD_CTL_SZ_LO], src_addr[grant]);
                     mem_read       <= 1'b1;
                     state          <= ST_READ;
                  end
               end
            end
            ST_FETCH: begin
               if (mem_ack) begin
                  mem_read       <= 1'b0;
                  rd_addr        <= mem_readdata;                 // see [R5]
                  mem_address    <= mem_readdata;
                  mem_byteenable <= lane_mask(csz, mem_readdata);
                  state          <= ST_READ;
               end
            end
            ST_READ: begin
               mem_read <= 1'b1;
               if (mem_ack & mem_read) begin
                  mem_read       <= 1'b0;
                  mem_writedata  <= mem_readdata;
                  mem_address    <= dst_addr[cur];               // see [R4]
                  mem_byteenable <= lane_mask(csz, dst_addr[cur]); // see [R2]
                  mem_write      <= 1'b1;
                  state          <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (mem_ack) begin
                  mem_write <= 1'b0;
                  mem_byteenable <= 4'h0;
                  if (cctl[`FCD_CTL_SINC])
                     src_addr[cur] <= (cind ? src_addr[cur] + 32'h4
                                      : rd_addr + unit_step(csz)); // see [R18]
                  if (crel) begin
                     reload_cnt <= reload_cnt + 2'h1;
                     if (reload_cnt == `FCD_RELOAD_EVERY)
                        src_addr[cur] <= src_orig[cur];          // see [R7]
                  end
                  if (cctl[`FCD_CTL_DINC])
                     dst_addr[cur] <= dst_addr[cur] + unit_step(csz); // see [R18]
                  remaining_transfer_count[cur] <= cnt_next;     // see [R18]
                  if (last_unit) begin
                     channel_control[cur][`FCD_CTL_DONE] <= 1'b1; // see [R14]
                     reload_cnt <= 2'h0;
                  end
                  peri_ack[cur] <= 1'b1;
                  state <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               // Burst keeps the bus for the same channel; steal rearbitrates
               if (cctl[`FCD_CTL_BURST] & req[cur] &
                   ~channel_control[cur][`FCD_CTL_DONE]) begin   // see [R11]
                  mem_address    <= src_addr[cur];
                  mem_byteenable <= cind ? 4'hf : lane_mask(csz, src_addr[cur]);
                  rd_addr        <= src_addr[cur];
                  mem_read       <= 1'b1;
                  state          <= cind ? ST_FETCH : ST_READ;
               end else begin
                  state <= ST_IDLE;                              // see [R11]
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // External acknowledge strobe, one cycle after each unit
   // ****************************************************************
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         transfer_ack_strobe <= 2'h0;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            transfer_ack_strobe[i] <= (state == ST_WRITE) & mem_ack &
               (cur == i) &
               (channel_control[i][`FCD_CTL_SRC_H:`FCD_CTL_SRC_L] ==
                `FCD_SRC_EXT);                                   // see [R16]
         end
      end
   end

endmodule // fcd_dma

// *** rtl/fcd_map.vh ***
// Register map, field positions and constants of the four-channel DMA.
// Assumes inclusion by the DMA controller only; definitions only.
`ifndef FCD_MAP_VH
`define FCD_MAP_VH

// ****************************************************************
// Register byte offsets (word index * 4)
// ****************************************************************
`define FCD_CH_BASE      8'h20
`define FCD_CH_STRIDE    8'h10
`define FCD_OFS_SRC      2'h0
`define FCD_OFS_DST      2'h1
`define FCD_OFS_CNT      2'h2
`define FCD_OFS_CTL      2'h3
`define FCD_OPER_ADDR    8'h60
`define FCD_ADDR_W       8

// ****************************************************************
// Channel control fields
// ****************************************************************
`define FCD_CTL_EN       0
`define FCD_CTL_DONE     1
`define FCD_CTL_IE       2
`define FCD_CTL_BURST    3
`define FCD_CTL_SZ_LO    4
`define FCD_CTL_SZ_HI    5
`define FCD_CTL_SRC_L    8
`define FCD_CTL_SRC_H    9
`define FCD_CTL_EXT_EDGE 10
`define FCD_CTL_SINC     12
`define FCD_CTL_DINC     13
`define FCD_CTL_RELOAD   14
`define FCD_CTL_INDIRECT 15
`define FCD_CTL_MASK     32'h0000_f73f

// Request sources
`define FCD_SRC_AUTO     2'h0
`define FCD_SRC_EXT      2'h1
`define FCD_SRC_PERI     2'h2

// Unit sizes
`define FCD_SZ_8         2'h0
`define FCD_SZ_16        2'h1
`define FCD_SZ_32        2'h2

// ****************************************************************
// Shared operation control fields
// ****************************************************************
`define FCD_OP_ENABLE    0
`define FCD_OP_ERR       1
`define FCD_OP_RROBIN    3
`define FCD_OP_MASK      16'h0009

// Counts
`define FCD_CNT_W        24
`define FCD_RELOAD_EVERY 2'h3
`define FCD_ACK_CYCLES   2'h1

`endif

// *** testbench/fcd_dma_properties.sv ***
// Checker on the DMA block ports: bus answers, memory handshake, strobes.
// Assumes binding to fcd_dma; sees only its ports.
`timescale 1ns/100ps
module fcd_chk (
   input wire        sys_clk,
   input wire        arst_n,
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire [1:0]  avs_response,
   input wire [1:0]  transfer_ack_strobe,
   input wire [3:0]  peri_ack,
   input wire [31:0] mem_address,
   input wire        mem_read,
   input wire        mem_write,
   input wire        mem_ack,
   input wire        irq
);
   wire      mapped = avs_address >= 8'h20 && avs_address < 8'h64 &&
                      avs_address[1:0] == 2'h0;
   reg [3:0] since_wr;
   // Saturates so an old write never looks recent
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         since_wr <= 4'hf;
      else if (mem_write && mem_ack)
         since_wr <= 4'h0;
      else if (since_wr != 4'hf)
         since_wr <= since_wr + 4'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // ****************************************************************
   // Properties
   // ****************************************************************
   a_rw_excl: assert property (
      !(mem_read && mem_write)) else $error("read and write together");
   a_req_hold: assert property (
      (mem_read || mem_write) && !mem_ack |=> (mem_read || mem_write)
      && $stable(mem_address) && $stable(mem_write))
      else $error("memory request dropped early");
   a_ack_pulse: assert property (
      (transfer_ack_strobe & $past(transfer_ack_strobe)) == 2'h0)
      else $error("ack strobe longer than one cycle");
   a_peri_pulse: assert property (
      (peri_ack & $past(peri_ack)) == 4'h0)
      else $error("peripheral ack longer than one cycle");
   a_unmapped_read: assert property (
      avs_read && !mapped |=> avs_response == 2'h3 && avs_readdata == 32'h0)
      else $error("unmapped read answered");
   a_mapped_read: assert property (
      avs_read && mapped |=> avs_response == 2'h0)
      else $error("mapped read refused");
   a_cnt_upper: assert property (
      avs_read && mapped && avs_address[3:2] == 2'h2
      |=> avs_readdata[31:24] == 8'h0) else $error("count upper bits set");
   a_irq_cause: assert property (
      $rose(irq) |-> since_wr < 4'h6 || $past(avs_write))
      else $error("interrupt without completed transfer");
endmodule // fcd_chk
bind fcd_dma fcd_chk fcd_chk_i (
   .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_response(avs_response), .transfer_ack_strobe(transfer_ack_strobe),
   .peri_ack(peri_ack), .mem_address(mem_address), .mem_read(mem_read),
   .mem_write(mem_write), .mem_ack(mem_ack), .irq(irq));

// *** testbench/fcd_mem_model.sv ***
// Memory on the DMA master side: 64 words, optional stall per access.
// Assumes the request is held until mem_ack, which pulses one cycle.
`timescale 1ns/100ps
module fcd_mem_model (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        slow,
   input  wire [31:0] mem_address,
   input  wire        mem_read,
   input  wire        mem_write,
   input  wire [31:0] mem_writedata,
   input  wire [3:0]  mem_byteenable,
   output reg  [31:0] mem_readdata,
   output reg         mem_ack
);
   reg [31:0] mem [0:63];
   reg [1:0]  stall;
   integer    i;
   wire [5:0] idx = mem_address[7:2];
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack      <= 1'b0;
         stall        <= 2'h0;
         mem_readdata <= 32'h0;
      end else begin
         mem_ack      <= 1'b0;
         // Stale data flips so a late sample is caught
         mem_readdata <= ~mem_readdata;
         if ((mem_read || mem_write) && !mem_ack) begin
            if (slow && stall != 2'h2)
               stall <= stall + 2'h1;
            else begin
               stall   <= 2'h0;
               mem_ack <= 1'b1;
               if (mem_read)
                  mem_readdata <= mem[idx];
               for (i = 0; i < 4; i = i + 1)
                  if (mem_write && mem_byteenable[i])
                     mem[idx][8*i +: 8] <= mem_writedata[8*i +: 8];
            end
         end
      end
   end
endmodule // fcd_mem_model

// *** testbench/testbench.sv ***
// Self-checking bench of the DMA block: register tasks, transfer runs.
// Assumes the memory model on the master side and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   miscompares++; $display("unexpected %s exp %h got %h", nm, ex, got); \
   end end
`define MEM(x) fcd_mem_model_i.mem[x]
module testbench;
   reg         sys_clk, arst_n, avs_read, avs_write, slow;
   reg  [7:0]  avs_address;
   reg  [31:0] avs_writedata, rd;
   reg  [1:0]  ext_transfer_request, rsp;
   reg  [3:0]  peri_request;
   wire [31:0] avs_readdata, mem_address, mem_writedata, mem_readdata;
   wire [1:0]  avs_response, transfer_ack_strobe;
   wire [3:0]  peri_ack, mem_byteenable;
   wire        avs_waitrequest, mem_read, mem_write, mem_ack, irq;
   integer     miscompares = 0, n_tests = 0, acks = 0, packs = 0, i;
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      acks  <= acks + transfer_ack_strobe[0];
      packs <= packs + peri_ack[3];
   end
   fcd_dma fcd_dma_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .peri_request(peri_request),
      .ext_transfer_request(ext_transfer_request), .peri_ack(peri_ack),
      .transfer_ack_strobe(transfer_ack_strobe), .mem_address(mem_address),
      .mem_read(mem_read), .mem_write(mem_write), .mem_ack(mem_ack),
      .mem_writedata(mem_writedata), .mem_byteenable(mem_byteenable),
      .mem_readdata(mem_readdata), .irq(irq));
   fcd_mem_model fcd_mem_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .slow(slow), .mem_address(mem_address), .mem_read(mem_read),
      .mem_write(mem_write), .mem_writedata(mem_writedata),
      .mem_byteenable(mem_byteenable), .mem_readdata(mem_readdata),
      .mem_ack(mem_ack));
   // Answer is taken at the accepting edge; one idle edge between calls
   task bus(input w, input [7:0] a, input [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      rd  = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge sys_clk);
   endtask
   task prog(input [7:0] b, input [31:0] s, d, c, ctl);
      bus(1, b, s);
      bus(1, b + 8'h4, d);
      bus(1, b + 8'h8, c);
      bus(1, b + 8'hc, ctl);
   endtask
   task wait_done(input [7:0] a);
      integer k;
      rd = 32'h0;
      for (k = 0; k < 300 && rd[1] !== 1'b1; k++)
         bus(0, a, 32'h0);
      if (rd[1] !== 1'b1) miscompares++;
   endtask
   task end_of_test;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      end_of_test;
   end
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      arst_n = 1'b0;
      {avs_read, avs_write, slow, avs_address, avs_writedata} = 0;
      ext_transfer_request = 2'h0;
      peri_request = 4'h0;
      for (i = 0; i < 64; i++)
         `MEM(i) = 32'h10203040 + i * 32'h01010101;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      bus(0, 8'h2c, 0);
      `CHK("ctl reset", 32'h0, rd)
      bus(0, 8'h04, 0);
      `CHK("unmapped", 2'h3, rsp)
      bus(1, 8'h28, 32'hffffffff);
      bus(0, 8'h28, 0);
      `CHK("count width", 32'h00ffffff, rd)
      bus(1, 8'h60, 32'h1);
      prog(8'h30, 32'h0, 32'h80, 32'h3, 32'h302d);
      wait_done(8'h3c);
      `CHK("done", 1'b1, rd[1])
      for (i = 0; i < 3; i++)
         `CHK("burst", `MEM(i), `MEM(32 + i))
      `CHK("irq set", 1'b1, irq)
      bus(0, 8'h38, 0);
      `CHK("count left", 32'h0, rd)
      bus(0, 8'h30, 0);
      `CHK("src next", 32'hc, rd)
      bus(1, 8'h3c, 32'h302c);
      bus(0, 8'h3c, 0);
      `CHK("done clear", 1'b0, rd[1])
      `CHK("irq clear", 1'b0, irq)
      bus(1, 8'h3c, 32'h6);
      bus(0, 8'h3c, 0);
      `CHK("done by one", 1'b0, rd[1])
      `MEM(40) = 32'hffffffff;
      prog(8'h20, 32'h10, 32'ha0, 32'h2, 32'h3101);
      repeat (20) @(posedge sys_clk);
      bus(0, 8'h28, 0);
      `CHK("no request", 32'h2, rd)
      ext_transfer_request <= 2'h1;
      wait_done(8'h2c);
      ext_transfer_request <= 2'h0;
      `CHK("bytes", {16'hffff, `MEM(4)[15:0]}, `MEM(40))
      `CHK("ack count", 2, acks)
      slow <= 1'b1;
      prog(8'h40, 32'h20, 32'hc0, 32'h8, 32'h7021);
      wait_done(8'h4c);
      for (i = 0; i < 8; i++)
         `CHK("reload", `MEM(8 + i % 4), `MEM(48 + i))
      slow <= 1'b0;
      `MEM(12) = 32'h38;
      `MEM(14) = 32'h1234abcd;
      prog(8'h50, 32'h30, 32'he0, 32'h1, 32'hb221);
      peri_request <= 4'h8;
      wait_done(8'h5c);
      peri_request <= 4'h0;
      `CHK("indirect", 32'h1234abcd, `MEM(56))
      `CHK("peri acks", 1, packs)
      end_of_test;
   end
endmodule // testbench
